// >>> tpwm_regs.svh
`ifndef TPWM_REGS_SVH
`define TPWM_REGS_SVH
`define TPWM_CNT_W        16
`define TPWM_CNT_RST      16'h0000
`define TPWM_MOD_RST      16'h0000
`define TPWM_MOD_ALL1     16'hffff
`define TPWM_CH_N         2
`define TPWM_CLKS_OFF     2'h0
`define TPWM_CLKS_BUS     2'h1
`define TPWM_CLKS_FIXED   2'h2
`define TPWM_CLKS_EXT     2'h3
`define TPWM_PS_W         3
`define TPWM_MODE_IC      2'h0
`define TPWM_MODE_OC      2'h1
`define TPWM_MODE_PWM     2'h2
`endif

// >>> tpwm_pkg.sv
package tpwm_pkg;
  typedef logic [15:0] tpwm_cnt_t;
  typedef logic [1:0]  tpwm_clks_t;
  typedef logic [1:0]  tpwm_mode_t;
  typedef logic [1:0]  tpwm_els_t;
endpackage

// >>> tpwm_core.sv
`timescale 1ns/1ps
`include "tpwm_regs.svh"
// How it works
// - every channel owns one two-way pin that it shares with a general-purpose port bit.
// - a 16-bit main counter is the time base for capture, compare and edge-aligned pwm.
// - the counter counts up to the modulo value, and a modulo of all zeros or all ones runs it free.
// - reading the counter never disturbs the counting sequence.
// - any write to the high or low counter byte clears the counter whatever the data.
// - each channel is set on its own as input capture, output compare or buffered pwm.
// - with the channel 0 pin as external clock, channel 0 leaves the pin but can still compare.
// - a pin used as a timer input may have its passive pull-up enabled.
// - after reset the timer is off and all pins are plain inputs with pull-ups off.
// - clock select 1:1 drives the prescaler and counter from the channel 0 pin.
// - the external clock is synchronised to the bus clock before any timer logic sees it.
// - a pin owned by the timer ignores port data and direction; otherwise the port rules it.
// - clock source and prescale divisor are selectable and each channel has a maskable interrupt.
// - with centre-align set and a modulo that does not run it free the counter counts up and down; all channels run centre-aligned pwm.
module tpwm_core (
  input  wire logic                      clk_sys_in,
  input  wire logic                      reset_n_in,
  input  wire tpwm_pkg::tpwm_clks_t      clock_select_in,
  input  wire logic [2:0]                prescale_in,
  input  wire logic                      center_align_select_in,
  input  wire logic [15:0]               modulo_in,
  input  wire logic                      counter_write_in,
  input  wire logic                      fixed_tick_in,
  input  wire logic                      overflow_clear_in,
  input  wire logic                      overflow_int_en_in,
  input  wire tpwm_pkg::tpwm_mode_t      ch_mode_in      [2],
  input  wire tpwm_pkg::tpwm_els_t       ch_edge_sel_in  [2],
  input  wire logic [15:0]               ch_value_in     [2],
  input  wire logic                      ch_flag_clear_in[2],
  input  wire logic                      ch_int_en_in    [2],
  input  wire logic                      ch_pullup_req_in[2],
  input  wire logic                      port_data_in    [2],
  input  wire logic                      port_dir_in     [2],
  input  wire logic                      timer_channel_pin_in [2],
  output logic                           timer_channel_pin_out[2],
  output logic                           timer_channel_pin_oe_n_out[2],
  output logic                           pullup_en_out   [2],
  output logic [15:0]                    main_counter_out,
  output logic                           overflow_flag_out,
  output logic [15:0]                    ch_capture_out  [2],
  output logic                           ch_flag_out     [2],
  output logic                           timer_irq_out
);
  import tpwm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage read only by the second
  logic [1:0] pin_s1_q, pin_s1_d;
  logic [1:0] pin_s2_q, pin_s2_d;
  logic       ext_prev_q, ext_prev_d;

  always_comb begin
    pin_s1_d   = {timer_channel_pin_in[1], timer_channel_pin_in[0]};
    pin_s2_d   = pin_s1_q;
    ext_prev_d = pin_s2_q[0];
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_s1_q   <= 2'h0;
      pin_s2_q   <= 2'h0;
      ext_prev_q <= 1'b0;
    end else begin
      pin_s1_q   <= pin_s1_d;
      pin_s2_q   <= pin_s2_d;
      ext_prev_q <= ext_prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock source and prescaler
  logic       src_tick;
  logic       ext_mode;
  logic [6:0] ps_q, ps_d;
  logic       cnt_tick;

  assign ext_mode = (clock_select_in == `TPWM_CLKS_EXT);

  // source select and divide by 2^prescale
  always_comb begin
    unique case (clock_select_in)
      `TPWM_CLKS_BUS:   src_tick = 1'b1;
      `TPWM_CLKS_FIXED: src_tick = fixed_tick_in;
      `TPWM_CLKS_EXT:   src_tick = pin_s2_q[0] & ~ext_prev_q;
      default:          src_tick = 1'b0;
    endcase
    ps_d     = ps_q;
    cnt_tick = 1'b0;
    if (clock_select_in == `TPWM_CLKS_OFF) begin
      ps_d = 7'h00;
    end else if (src_tick) begin
      // divisor mask: counter fires when low prescale bits wrap
      if ((ps_q & ((7'h01 << prescale_in) - 7'h01)) == ((7'h01 << prescale_in) - 7'h01)) begin
        cnt_tick = 1'b1;
      end
      ps_d = ps_q + 7'h01;
    end
    if (counter_write_in) begin
      ps_d = 7'h00;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) ps_q <= 7'h00;
    else             ps_q <= ps_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // main counter, up or up/down
  logic [15:0] cnt_q, cnt_d;
  logic        down_q, down_d;
  logic        ovf_q, ovf_d;
  logic        free_run;
  logic        ovf_evt;

  assign free_run = (modulo_in == `TPWM_MOD_RST) || (modulo_in == `TPWM_MOD_ALL1);

  always_comb begin
    cnt_d   = cnt_q;
    down_d  = down_q;
    ovf_evt = 1'b0;
    if (cnt_tick) begin
      if (center_align_select_in && !free_run) begin
        if (!down_q) begin
          if (cnt_q >= modulo_in) begin
            down_d = 1'b1;
            cnt_d  = cnt_q - 16'h0001;
          end else begin
            cnt_d = cnt_q + 16'h0001;
          end
        end else if (cnt_q == `TPWM_CNT_RST) begin
          down_d  = 1'b0;
          cnt_d   = cnt_q + 16'h0001;
          ovf_evt = 1'b1;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end else if (!free_run && cnt_q == modulo_in) begin
        cnt_d   = `TPWM_CNT_RST;
        ovf_evt = 1'b1;
      end else begin
        // free running wraps at all ones
        cnt_d   = cnt_q + 16'h0001;
        ovf_evt = (cnt_q == `TPWM_MOD_ALL1);
      end
    end
    if (counter_write_in) begin
      cnt_d  = `TPWM_CNT_RST;
      down_d = 1'b0;
    end
    // set wins over clear
    ovf_d = ovf_evt | (ovf_q & ~overflow_clear_in);
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_q  <= `TPWM_CNT_RST;
      down_q <= 1'b0;
      ovf_q  <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      down_q <= down_d;
      ovf_q  <= ovf_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channels
  logic        own_d   [2];
  logic        pin_o_d [2];
  logic        oe_n_d  [2];
  logic        pu_d    [2];
  logic [15:0] cap_d   [2];
  logic        flg_d   [2];
  logic [15:0] buf_d   [2];
  logic        pwm_d   [2];
  logic        own_q   [2];
  logic        pin_o_q [2];
  logic        oe_n_q  [2];
  logic        pu_q    [2];
  logic [15:0] cap_q   [2];
  logic        flg_q   [2];
  logic [15:0] buf_q   [2];
  logic        pwm_q   [2];
  logic [1:0]  in_prev_q;
  logic        irq_q, irq_d;

  always_comb begin
    irq_d = overflow_int_en_in & ovf_q;
    for (int i = 0; i < 2; i++) begin
      own_d[i]   = 1'b0;
      pin_o_d[i] = pin_o_q[i];
      oe_n_d[i]  = 1'b1;
      pu_d[i]    = 1'b0;
      cap_d[i]   = cap_q[i];
      buf_d[i]   = buf_q[i];
      pwm_d[i]   = pwm_q[i];
      flg_d[i]   = flg_q[i] & ~ch_flag_clear_in[i];
      if (center_align_select_in) begin
        own_d[i] = (ch_edge_sel_in[i] != 2'h0);
        if (cnt_tick && cnt_q == buf_q[i]) begin
          pwm_d[i] = ~pwm_q[i];
          flg_d[i] = 1'b1;
        end
        if (cnt_tick && cnt_q == `TPWM_CNT_RST) begin
          buf_d[i] = ch_value_in[i];
          pwm_d[i] = ch_edge_sel_in[i][0];
        end
        pin_o_d[i] = pwm_d[i];
      end else begin
        unique case (ch_mode_in[i])
          `TPWM_MODE_IC: begin
            if (ch_edge_sel_in[i] != 2'h0) begin
              own_d[i] = 1'b1;
              if ((ch_edge_sel_in[i][0] & pin_s2_q[i] & ~in_prev_q[i]) |
                  (ch_edge_sel_in[i][1] & ~pin_s2_q[i] & in_prev_q[i])) begin
                cap_d[i] = cnt_q;
                flg_d[i] = 1'b1;
              end
            end
          end
          `TPWM_MODE_OC: begin
            // compare still flags with no pin
            own_d[i] = (ch_edge_sel_in[i] != 2'h0);
            if (cnt_tick && cnt_q == ch_value_in[i]) begin
              flg_d[i] = 1'b1;
              unique case (ch_edge_sel_in[i])
                2'h1:    pin_o_d[i] = ~pin_o_q[i];
                2'h2:    pin_o_d[i] = 1'b0;
                default: pin_o_d[i] = 1'b1;
              endcase
            end
          end
          default: begin
            // buffered edge-aligned pwm, reload on counter wrap
            own_d[i] = (ch_edge_sel_in[i] != 2'h0);
            if (cnt_tick && cnt_q == buf_q[i]) begin
              pin_o_d[i] = ch_edge_sel_in[i][0];
              flg_d[i]   = 1'b1;
            end
            if (ovf_evt) begin
              buf_d[i]   = ch_value_in[i];
              pin_o_d[i] = ~ch_edge_sel_in[i][0];
            end
          end
        endcase
      end
      // external clock takes channel 0 pin
      if (i == 0 && ext_mode) begin
        own_d[i] = 1'b0;
      end
      if (own_d[i]) begin
        oe_n_d[i] = (!center_align_select_in && ch_mode_in[i] == `TPWM_MODE_IC);
      end else begin
        oe_n_d[i]  = ~port_dir_in[i];
        pin_o_d[i] = port_data_in[i];
      end
      pu_d[i] = oe_n_d[i] & ch_pullup_req_in[i] & (own_d[i] | (i == 0 && ext_mode));
      irq_d = irq_d | (ch_int_en_in[i] & flg_q[i]);
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < 2; i++) begin
        own_q[i]   <= 1'b0;
        pin_o_q[i] <= 1'b0;
        oe_n_q[i]  <= 1'b1;
        pu_q[i]    <= 1'b0;
        cap_q[i]   <= 16'h0000;
        flg_q[i]   <= 1'b0;
        buf_q[i]   <= 16'h0000;
        pwm_q[i]   <= 1'b0;
      end
      in_prev_q <= 2'h0;
      irq_q     <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        own_q[i]   <= own_d[i];
        pin_o_q[i] <= pin_o_d[i];
        oe_n_q[i]  <= oe_n_d[i];
        pu_q[i]    <= pu_d[i];
        cap_q[i]   <= cap_d[i];
        flg_q[i]   <= flg_d[i];
        buf_q[i]   <= buf_d[i];
        pwm_q[i]   <= pwm_d[i];
      end
      in_prev_q <= pin_s2_q;
      irq_q     <= irq_d;
    end
  end

  // registered pin and status outputs, plain reads
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      timer_channel_pin_out[i]      = pin_o_q[i];
      timer_channel_pin_oe_n_out[i] = oe_n_q[i];
      pullup_en_out[i]              = pu_q[i];
      ch_capture_out[i]             = cap_q[i];
      ch_flag_out[i]                = flg_q[i];
    end
    main_counter_out  = cnt_q;
    overflow_flag_out = ovf_q;
    timer_irq_out     = irq_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_clear;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      counter_write_in |=> (main_counter_out == 16'h0000);
  endproperty
  a_clear: assert property (p_clear) else $error("counter not cleared by write");

  property p_wrap;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      (cnt_tick && !counter_write_in && !center_align_select_in && !free_run && cnt_q == modulo_in)
      |=> (cnt_q == 16'h0000) && ovf_q;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap at modulo");

  property p_hold;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      (!cnt_tick && !counter_write_in) |=> $stable(cnt_q);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved without tick");

  property p_ext_free;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      ext_mode |=> !own_q[0];
  endproperty
  a_ext_free: assert property (p_ext_free) else $error("channel 0 holds pin in ext mode");

  property p_pullup;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      pu_q[0] |-> oe_n_q[0];
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up on driven pin");

  property p_port;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      (!own_d[1]) |=> (oe_n_q[1] == ~$past(port_dir_in[1]));
  endproperty
  a_port: assert property (p_port) else $error("port direction ignored");

  property p_ext_tick;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      (ext_mode && !pin_s2_q[0] && !ps_q[0] && prescale_in == 3'h0) |-> !cnt_tick;
  endproperty
  a_ext_tick: assert property (p_ext_tick) else $error("ext tick without edge");

  property p_free;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
      (cnt_tick && free_run && !center_align_select_in && !counter_write_in && cnt_q != 16'hffff)
      |=> (cnt_q == $past(cnt_q) + 16'h0001);
  endproperty
  a_free: assert property (p_free) else $error("free run not incrementing");
endmodule

// >>> tpwm_pin_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// far-side model of the two shared timer channel pins
module tpwm_pin_model #(
  parameter int HALF_NS = 430
) (
  input  wire logic        ext_run_in,
  input  wire logic        drive_in    [2],
  input  wire logic        level_in    [2],
  input  wire logic        dut_out_in  [2],
  input  wire logic        dut_oe_n_in [2],
  input  wire logic        pullup_in   [2],
  output logic             pin_out     [2],
  output logic [15:0]      ext_edges_out
);
  logic ext_clk_q;
  logic float_q;

  // external clock only runs while enabled, otherwise the line is released
  initial begin
    ext_clk_q     = 1'b0;
    float_q       = 1'b0;
    ext_edges_out = 16'h0000;
    forever begin
      wait (ext_run_in);
      // 860 ns period, under a quarter of the bus clock
      #(HALF_NS) ext_clk_q = 1'b1;
      ext_edges_out = ext_edges_out + 16'h0001;
      #(HALF_NS) ext_clk_q = 1'b0;
    end
  end

  // floating line wanders so a stale value never looks valid
  always #70 float_q = ~float_q;

  // resolve the wire level from every party that may drive it
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (!dut_oe_n_in[i]) begin
        pin_out[i] = dut_out_in[i];
      end else if (i == 0 && ext_run_in) begin
        pin_out[i] = ext_clk_q;
      end else if (drive_in[i]) begin
        pin_out[i] = level_in[i];
      end else if (pullup_in[i]) begin
        pin_out[i] = 1'b1;
      end else begin
        pin_out[i] = float_q;
      end
    end
  end
endmodule

// >>> tb_tpwm_core.sv
`timescale 1ns/1ps
module tb_tpwm_core;
  import tpwm_pkg::*;
  logic        clk_sys = 1'b0, reset_n = 1'b0, center = 1'b0, cnt_wr = 1'b0;
  logic        ovf_clr = 1'b0, ovf_ie = 1'b0, ext_run = 1'b0, ovf, irq;
  tpwm_clks_t  clk_sel = 2'h0;
  logic [2:0]  presc = 3'h0;
  logic [15:0] modulo = 16'h0000, cnt, edges, c;
  tpwm_mode_t  ch_mode[2] = '{2'h0, 2'h0};
  tpwm_els_t   ch_els[2] = '{2'h0, 2'h0};
  logic [15:0] ch_val[2] = '{16'h0100, 16'h0014}, ch_cap[2];
  logic        ch_fclr[2] = '{1'b0, 1'b0}, ch_ie[2] = '{1'b0, 1'b0}, ch_pu[2] = '{1'b0, 1'b0};
  logic        p_data[2] = '{1'b0, 1'b0}, p_dir[2] = '{1'b0, 1'b0};
  logic        drv[2] = '{1'b0, 1'b0}, lvl[2] = '{1'b0, 1'b0};
  logic        pin[2], pin_o[2], pin_oe_n[2], pu_en[2], ch_flag[2];
  int          n_errors = 0, comparisons = 0, k;

  always #50 clk_sys = ~clk_sys;

  tpwm_core u_dut (.clk_sys_in(clk_sys), .reset_n_in(reset_n), .clock_select_in(clk_sel), .prescale_in(presc),
    .center_align_select_in(center), .modulo_in(modulo), .counter_write_in(cnt_wr), .fixed_tick_in(1'b0),
    .overflow_clear_in(ovf_clr), .overflow_int_en_in(ovf_ie), .ch_mode_in(ch_mode), .ch_edge_sel_in(ch_els),
    .ch_value_in(ch_val), .ch_flag_clear_in(ch_fclr), .ch_int_en_in(ch_ie), .ch_pullup_req_in(ch_pu),
    .port_data_in(p_data), .port_dir_in(p_dir), .timer_channel_pin_in(pin), .timer_channel_pin_out(pin_o),
    .timer_channel_pin_oe_n_out(pin_oe_n), .pullup_en_out(pu_en), .main_counter_out(cnt),
    .overflow_flag_out(ovf), .ch_capture_out(ch_cap), .ch_flag_out(ch_flag), .timer_irq_out(irq));

  tpwm_pin_model u_pins (.ext_run_in(ext_run), .drive_in(drv), .level_in(lvl), .dut_out_in(pin_o),
    .dut_oe_n_in(pin_oe_n), .pullup_in(pu_en), .pin_out(pin), .ext_edges_out(edges));

  ////////////////////////////////////////////////////////////////////////////////
  // inputs move only just after the falling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic give_up;
    n_errors++;
    $display("Error at %0t: wait ran out", $time);
    wrap_up();
  endtask

  // bounded wait for a counter value
  task automatic wait_cnt(input logic [15:0] v);
    for (k = 0; k < 400 && cnt !== v; k++) cyc(1);
    if (k == 400) give_up();
  endtask

  // counter write pulse, counter must read zero after one edge
  task automatic clear_cnt;
    cnt_wr = 1'b1;
    cyc(1);
    check(cnt, 16'h0000);
    cnt_wr = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(2);
    reset_n = 1'b1;
    check(cnt, 16'h0000);
    check(irq, 1'b0);
    for (int i = 0; i < 2; i++) begin
      check(pin_oe_n[i], 1'b1);
      check(pu_en[i], 1'b0);
    end
    cyc(3);
    check(cnt, 16'h0000);
    clk_sel = 2'h1;
    cyc(3);
    c = cnt;
    cyc(1);
    check(cnt, c + 16'h0001);
    cyc(5);
    check(cnt, c + 16'h0006);
    // both free-running codes, starting from zero so a wrap at zero shows
    foreach (ch_val[m]) begin
      modulo = (m == 0) ? 16'h0000 : 16'hffff;
      clear_cnt();
      cyc(1);
      c = cnt;
      cyc(10);
      check(cnt, c + 16'h000a);
    end
    // modulo wrap, overflow and its interrupt; start below the modulo or it runs to all ones
    modulo = 16'h0005;
    ovf_ie = 1'b1;
    clear_cnt();
    wait_cnt(16'h0005);
    cyc(1);
    check(cnt, 16'h0000);
    check(ovf, 1'b1);
    check(irq, 1'b0);
    cyc(1);
    check(irq, 1'b1);
    ovf_ie = 1'b0;
    cyc(2);
    check(irq, 1'b0);
    ovf_clr = 1'b1;
    cyc(1);
    ovf_clr = 1'b0;
    check(ovf, 1'b0);
    // divide by four
    modulo = 16'h0000;
    presc = 3'h2;
    clear_cnt();
    c = cnt;
    for (k = 0; k < 20 && cnt === c; k++) cyc(1);
    c = cnt;
    cyc(3);
    check(cnt, c);
    cyc(1);
    check(cnt, c + 16'h0001);
    presc = 3'h0;
    // channel with no pin leaves the port in charge
    p_dir[1] = 1'b1;
    p_data[1] = 1'b1;
    cyc(2);
    check(pin_oe_n[1], 1'b0);
    check(pin_o[1], 1'b1);
    p_dir[1] = 1'b0;
    cyc(2);
    check(pin_oe_n[1], 1'b1);
    // rising-edge capture on ch0 and set-on-match compare on ch1 side by side
    ch_els = '{2'h1, 2'h3};
    ch_mode = '{2'h0, 2'h1};
    ch_pu[0] = 1'b1;
    p_dir[1] = 1'b1;
    p_data[1] = 1'b0;
    ch_ie[1] = 1'b1;
    clear_cnt();
    cyc(2);
    check(pin_oe_n[0], 1'b1);
    check(pu_en[0], 1'b1);
    check(pin_oe_n[1], 1'b0);
    // park the pin low, then drop any flag left by the floating line
    drv[0] = 1'b1;
    cyc(3);
    ch_fclr[0] = 1'b1;
    cyc(1);
    ch_fclr[0] = 1'b0;
    check(ch_flag[0], 1'b0);
    // two sync flops then the edge: counter value two ticks on is captured
    c = cnt;
    lvl[0] = 1'b1;
    cyc(6);
    check(ch_flag[0], 1'b1);
    check(ch_cap[0], c + 16'h0002);
    wait_cnt(16'h0018);
    check(pin_o[1], 1'b1);
    check(ch_flag[1], 1'b1);
    check(irq, 1'b1);
    ch_fclr[1] = 1'b1;
    cyc(1);
    ch_fclr[1] = 1'b0;
    cyc(1);
    check(irq, 1'b0);
    // external clock on the channel 0 pin, channel 0 kept as compare only
    drv[0] = 1'b0;
    ch_mode[0] = 2'h1;
    ch_els[0] = 2'h0;
    clk_sel = 2'h3;
    cyc(3);
    check(pin_oe_n[0], 1'b1);
    check(pu_en[0], 1'b1);
    clear_cnt();
    c = edges;
    ext_run = 1'b1;
    for (k = 0; k < 100 && edges !== c + 16'h0005; k++) cyc(1);
    if (k == 100) give_up();
    cyc(4);
    clk_sel = 2'h0;
    cyc(1);
    check(cnt, 16'h0005);
    ext_run = 1'b0;
    // centre-aligned climbs from zero to the modulo and counts back down
    clk_sel = 2'h1;
    center = 1'b1;
    modulo = 16'h0003;
    clear_cnt();
    wait_cnt(16'h0003);
    cyc(1);
    check(cnt, 16'h0002);
    cyc(1);
    check(cnt, 16'h0001);
    check(pin_oe_n[1], 1'b0);
    wrap_up();
  end

  // hang guard
  initial begin
    #5000000;
    give_up();
  end
endmodule
